/* design/pa_pkg.sv */
package pa_pkg;
   // pins of the port that exist; bits one and two are not bonded out
   localparam logic [7:0] PA_PIN_MASK = 8'hf9;
   // pins that can feed the comparator minus input
   localparam logic [7:0] PA_MINUS_MASK = 8'hd8;
   // pin positions
   localparam int PA_BIT_ZERO = 0;
   localparam int PA_BIT_THREE = 3;
   localparam int PA_BIT_FOUR = 4;
   localparam int PA_BIT_FIVE = 5;
   localparam int PA_BIT_SIX = 6;
   localparam int PA_BIT_SEVEN = 7;
   // values after reset
   localparam logic [7:0] PA_RST_BYTE = 8'h00;
   localparam logic PA_RST_LOW = 1'b0;
   localparam logic PA_RST_HIGH = 1'b1;
   // timer pwm routing, one-hot
   typedef enum logic [2:0]
   {
      PA_PWM_OFF = 3'b001,
      PA_PWM_BIT3 = 3'b010,
      PA_PWM_BIT4 = 3'b100
   } pa_pwm_route_type;
   // comparator minus input source
   typedef enum logic [1:0]
   {
      PA_MINUS_BIT3 = 2'h0,
      PA_MINUS_BIT4 = 2'h1,
      PA_MINUS_BIT6 = 2'h2,
      PA_MINUS_BIT7 = 2'h3
   } pa_minus_src_type;
endpackage

/* design/pa_in_gate.sv */
`timescale 1ns/1ps
`default_nettype none
module pa_in_gate
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // pin levels and enables
   input wire logic [7:0] pin_level,
   input wire logic [7:0] dig_in_en,
   // gated read value and per-pin change pulses
   output logic [7:0] read_value,
   output logic [7:0] pin_change
);
   import pa_pkg::*;

   logic [7:0] read_reg;
   logic [7:0] read_next;
   logic [7:0] prev_reg;
   logic [7:0] prev_next;
   logic primed_reg;
   logic primed_next;

   ////////////////////////////////////////////////////////////////////////
   // a disabled input reads as constant zero; past the one falling edge when a high pin is disabled it makes no edges
   always_comb
   begin
      read_next = pin_level & dig_in_en & PA_PIN_MASK;
      // first sample loads both copies: no false edge out of reset
      prev_next = primed_reg ? read_reg : read_next;
      primed_next = PA_RST_HIGH;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         read_reg <= PA_RST_BYTE;
         prev_reg <= PA_RST_BYTE;
         primed_reg <= PA_RST_LOW;
      end
      else
      begin
         read_reg <= read_next;
         prev_reg <= prev_next;
         primed_reg <= primed_next;
      end
   end

   assign read_value = read_reg;
   assign pin_change = read_reg ^ prev_reg; // both edges

   chk_gated_read_zero: assert property (@(posedge mclk) disable iff (!rst_n)
      1'b1 |=> ((read_value & ~$past(dig_in_en)) == 8'h00))
      else $error("disabled pin input not held at zero");
endmodule
`default_nettype wire

/* design/pa_port_pins.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// - input enable low cuts a pin's digital input and its sleep wake-up, but not the bit five reset input.
// - ordinary pins are input or push-pull output, optional pull-high.
// - bit five is input or open-drain with pull-high, or reset input.
// - bit zero as interrupt line requests on rising and falling edges.
// - bit zero can drive the comparator result out instead.
// - comparator plus from bit four; minus from bits three, four, six, seven.
// - timer pwm can replace port output on bit three or four.
// - each pin can wake from sleep on change, gated by input enable.
module pa_port_pins
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // pad side
   input wire logic [7:0] pad_in,
   output logic [7:0] pad_out,
   output logic [7:0] pad_oe,
   output logic [7:0] pull_high_on,
   // port configuration
   input wire logic [7:0] port_out_data,
   input wire logic [7:0] port_dir_out,
   input wire logic [7:0] pull_high_en,
   input wire logic [7:0] dig_in_en,
   input wire logic [7:0] wake_en,
   input wire logic sleep_mode,
   input wire logic reset_pin_en,
   // interrupt and comparator
   input wire logic ext_int_en,
   input wire logic comp_out_en,
   input wire logic comparator_result_out,
   input wire logic comp_plus_en,
   input wire logic comp_minus_en,
   input wire pa_pkg::pa_minus_src_type comp_minus_src,
   // timer pwm
   input wire pa_pkg::pa_pwm_route_type pwm_route,
   input wire logic timer8_pwm_out,
   // status
   output logic [7:0] port_read,
   output logic external_interrupt_line,
   output logic wake_req,
   output logic hardware_reset_pin_n,
   output logic comparator_plus_in_sel,
   output logic [7:0] comparator_minus_in_sel
);
   import pa_pkg::*;

   // one-hot pin select from a bit position
   function automatic logic [7:0] pa_pin_hot(input int pos);
      logic [7:0] hot;
      hot = 8'h01 << pos[2:0];
      return hot;
   endfunction

   // minus source to pin position
   function automatic int pa_minus_pos(input pa_minus_src_type src);
      int pos;
      pos = PA_BIT_THREE;
      unique case (src)
         PA_MINUS_BIT3: pos = PA_BIT_THREE;
         PA_MINUS_BIT4: pos = PA_BIT_FOUR;
         PA_MINUS_BIT6: pos = PA_BIT_SIX;
         PA_MINUS_BIT7: pos = PA_BIT_SEVEN;
      endcase
      return pos;
   endfunction

   logic [7:0] pin_change;
   logic [7:0] out_reg;
   logic [7:0] out_next;
   logic [7:0] oe_reg;
   logic [7:0] oe_next;
   logic [7:0] pull_reg;
   logic [7:0] pull_next;
   logic [7:0] minus_reg;
   logic [7:0] minus_next;
   logic plus_reg;
   logic plus_next;
   logic int_reg;
   logic int_next;
   logic wake_reg;
   logic wake_next;
   logic rstpin_reg;
   logic rstpin_next;

   ////////////////////////////////////////////////////////////////////////
   // input gating and edge detection
   pa_in_gate u_in_gate
   (
      .mclk(mclk),
      .rst_n(rst_n),
      .pin_level(pad_in),
      .dig_in_en(dig_in_en),
      .read_value(port_read),
      .pin_change(pin_change)
   );

   ////////////////////////////////////////////////////////////////////////
   // pad drive, pull-high and analog select
   always_comb
   begin
      out_next = port_out_data;
      oe_next = port_dir_out;
      // bit five only sinks; high comes from the pull-high
      out_next[PA_BIT_FIVE] = 1'b0;
      oe_next[PA_BIT_FIVE] = port_dir_out[PA_BIT_FIVE] & ~port_out_data[PA_BIT_FIVE];
      if (reset_pin_en)
      begin
         oe_next[PA_BIT_FIVE] = 1'b0;
      end
      if (comp_out_en)
      begin
         out_next[PA_BIT_ZERO] = comparator_result_out;
         oe_next[PA_BIT_ZERO] = 1'b1;
      end
      if (pwm_route == PA_PWM_BIT3)
      begin
         out_next[PA_BIT_THREE] = timer8_pwm_out;
         oe_next[PA_BIT_THREE] = 1'b1;
      end
      if (pwm_route == PA_PWM_BIT4)
      begin
         out_next[PA_BIT_FOUR] = timer8_pwm_out;
         oe_next[PA_BIT_FOUR] = 1'b1;
      end
      // analog use releases the driver so it cannot fight the source
      plus_next = comp_plus_en;
      minus_next = comp_minus_en ? pa_pin_hot(pa_minus_pos(comp_minus_src)) : PA_RST_BYTE;
      if (plus_next)
      begin
         oe_next[PA_BIT_FOUR] = 1'b0;
      end
      oe_next = oe_next & ~minus_next & PA_PIN_MASK;
      out_next = out_next & oe_next;
      // pull-high only while the pin is not driven
      pull_next = pull_high_en & ~oe_next & PA_PIN_MASK;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_reg <= PA_RST_BYTE;
         oe_reg <= PA_RST_BYTE;
         pull_reg <= PA_RST_BYTE;
         minus_reg <= PA_RST_BYTE;
         plus_reg <= PA_RST_LOW;
      end
      else
      begin
         out_reg <= out_next;
         oe_reg <= oe_next;
         pull_reg <= pull_next;
         minus_reg <= minus_next;
         plus_reg <= plus_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt, wake-up and reset pin events
   always_comb
   begin
      // comparator output on bit zero would trigger itself, so it masks the line
      int_next = ext_int_en & ~comp_out_en & pin_change[PA_BIT_ZERO];
      wake_next = sleep_mode & (|(pin_change & wake_en & dig_in_en));
      // reset taps the raw pad so a cleared input enable cannot lock it out
      rstpin_next = reset_pin_en ? pad_in[PA_BIT_FIVE] : PA_RST_HIGH;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         int_reg <= PA_RST_LOW;
         wake_reg <= PA_RST_LOW;
         rstpin_reg <= PA_RST_HIGH;
      end
      else
      begin
         int_reg <= int_next;
         wake_reg <= wake_next;
         rstpin_reg <= rstpin_next;
      end
   end

   assign pad_out = out_reg;
   assign pad_oe = oe_reg;
   assign pull_high_on = pull_reg;
   assign comparator_minus_in_sel = minus_reg;
   assign comparator_plus_in_sel = plus_reg;
   assign external_interrupt_line = int_reg;
   assign wake_req = wake_reg;
   assign hardware_reset_pin_n = rstpin_reg;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_int_edge;
      ext_int_en && !comp_out_en && pin_change[0];
   endsequence

   sequence s_wake_cause;
      sleep_mode && (|(pin_change & wake_en & dig_in_en));
   endsequence

   chk_den_wake_gate: assert property (wake_req |-> $past(|(pin_change & dig_in_en)))
      else $error("wake without an enabled input change");
   chk_push_pull: assert property ((port_dir_out[7] && !comp_minus_en)
      |=> (pad_oe[7] && pad_out[7] == $past(port_out_data[7])))
      else $error("push-pull output not driven");
   chk_open_drain: assert property (pad_oe[5] |-> !pad_out[5])
      else $error("bit five driven high");
   chk_reset_pin_follow: assert property (reset_pin_en |=> hardware_reset_pin_n == $past(pad_in[5]))
      else $error("reset pin level not passed on");
   chk_int_both_edges: assert property (s_int_edge |=> external_interrupt_line)
      else $error("interrupt edge missed");
   // a pulse only ever follows an unmasked edge, so it lasts one cycle per edge
   chk_int_pulse_only: assert property (external_interrupt_line |->
      $past(ext_int_en && !comp_out_en && pin_change[PA_BIT_ZERO]))
      else $error("interrupt without an edge");
   chk_comp_out_drive: assert property (comp_out_en |=> (pad_oe[0] && pad_out[0] == $past(comparator_result_out)))
      else $error("comparator result not on bit zero");
   chk_minus_sources: assert property ($onehot0(comparator_minus_in_sel)
      && ((comparator_minus_in_sel & ~PA_MINUS_MASK) == 8'h00))
      else $error("illegal comparator minus source");
   chk_pwm_route: assert property ((pwm_route == PA_PWM_BIT3 && !comp_minus_en)
      |=> (pad_oe[3] && pad_out[3] == $past(timer8_pwm_out)))
      else $error("pwm not routed to bit three");
   chk_wake_change: assert property (s_wake_cause |=> wake_req)
      else $error("enabled pin change did not wake");
endmodule
`default_nettype wire

/* tb/pa_pad_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pa_pad_model
(
   // clock
   input wire logic mclk,
   // device side
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe,
   input wire logic [7:0] pull_high_on,
   // outside drivers
   input wire logic [7:0] ext_val,
   input wire logic [7:0] ext_en,
   output logic [7:0] pad_in
);
   logic [7:0] last_reg = 8'h00;
   // remember the level so a floating pin can wander
   always_ff @(posedge mclk)
      last_reg <= pad_in;
   // device drive wins, then outside, then pull-high, else noise
   always_comb
      for (int i = 0; i < 8; i++)
         pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i]
            : pull_high_on[i] ? 1'b1 : ~last_reg[i];
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import pa_pkg::*;
   // pins and controls
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] pad_in, pad_out, pad_oe, pull_high_on, port_read, minus_sel;
   logic [7:0] ext_val = 8'h00, ext_en = 8'hff, data = 8'h00, dir = 8'h00;
   logic [7:0] pull = 8'h00, din = 8'hff, wake_en = 8'h00;
   logic sleep = 1'b0, rpin = 1'b0, int_en = 1'b0, co_en = 1'b0, cres = 1'b0;
   logic plus_en = 1'b0, minus_en = 1'b0, pwm = 1'b0, irq, wake, hrst_n, plus_sel;
   pa_minus_src_type src = PA_MINUS_BIT3;
   pa_pwm_route_type route = PA_PWM_OFF;
   int fails = 0;
   int total_checks = 0;
   ////////////////////////////////////////
   pa_port_pins pa_port_pins_i (.mclk(mclk), .rst_n(rst_n), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe(pad_oe), .pull_high_on(pull_high_on),
      .port_out_data(data), .port_dir_out(dir), .pull_high_en(pull),
      .dig_in_en(din), .wake_en(wake_en), .sleep_mode(sleep), .reset_pin_en(rpin),
      .ext_int_en(int_en), .comp_out_en(co_en), .comparator_result_out(cres),
      .comp_plus_en(plus_en), .comp_minus_en(minus_en), .comp_minus_src(src),
      .pwm_route(route), .timer8_pwm_out(pwm), .port_read(port_read),
      .external_interrupt_line(irq), .wake_req(wake), .hardware_reset_pin_n(hrst_n),
      .comparator_plus_in_sel(plus_sel), .comparator_minus_in_sel(minus_sel));
   pa_pad_model pa_pad_model_i (.mclk(mclk), .pad_out(pad_out), .pad_oe(pad_oe),
      .pull_high_on(pull_high_on), .ext_val(ext_val), .ext_en(ext_en),
      .pad_in(pad_in));
   ////////////////////////////////////////
   // settle just after an edge before looking
   task tick();
      @(posedge mclk);
      #1;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // pulse lands two edges after the pad moves, for one cycle only
   task automatic watch(input bit w, input logic e);
      for (int k = 0; k < 3; k++)
      begin
         tick();
         chk(w ? wake : irq, (k == 1) ? e : 1'b0);
      end
   endtask
   task test_done();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   ////////////////////////////////////////
   task t_drive();
      @(posedge mclk);
      ext_en <= 8'h5f;
      dir <= 8'ha0;
      data <= 8'ha0;
      pull <= 8'h20;
      tick();
      chk(pad_oe, 8'h80);
      chk(pad_out, 8'h80);
      chk(pull_high_on, 8'h20);
      tick();
      chk(port_read & 8'ha0, 8'ha0);
      @(posedge mclk);
      data <= 8'h80;
      tick();
      chk(pad_oe, 8'ha0);
      chk(pad_out, 8'h80);
      chk(pull_high_on, 8'h00);
      @(posedge mclk);
      dir <= 8'h00;
      ext_en <= 8'hff;
      pull <= 8'h00;
      rpin <= 1'b1;
      tick();
      chk(hrst_n, 1'b0);
      @(posedge mclk);
      ext_val[5] <= 1'b1;
      tick();
      chk(hrst_n, 1'b1);
      @(posedge mclk);
      rpin <= 1'b0;
      ext_val[5] <= 1'b0;
   endtask
   // both edges request; masked while the pin shows the comparator
   task t_irq();
      @(posedge mclk);
      int_en <= 1'b1;
      ext_val[0] <= 1'b1;
      watch(0, 1'b1);
      @(posedge mclk);
      ext_val[0] <= 1'b0;
      watch(0, 1'b1);
      @(posedge mclk);
      co_en <= 1'b1;
      cres <= 1'b1;
      tick();
      chk({pad_oe[0], pad_out[0]}, 2'b11);
      watch(0, 1'b0);
      @(posedge mclk);
      cres <= 1'b0;
      tick();
      chk({pad_oe[0], pad_out[0]}, 2'b10);
      @(posedge mclk);
      co_en <= 1'b0;
      int_en <= 1'b0;
   endtask
   task automatic t_comp();
      logic [7:0] e [4] = '{8'h08, 8'h10, 8'h40, 8'h80};
      // analog use must release the driver on the selected pins
      logic [7:0] o [5] = '{8'hc0, 8'hc8, 8'h88, 8'h48, 8'hd8};
      for (int i = 0; i < 5; i++)
      begin
         @(posedge mclk);
         dir <= 8'hd8;
         plus_en <= (i < 4);
         minus_en <= (i < 4);
         src <= pa_minus_src_type'(i[1:0]);
         tick();
         chk(minus_sel, (i < 4) ? e[i % 4] : 8'h00);
         chk(plus_sel, (i < 4));
         chk(pad_oe, o[i]);
      end
   endtask
   task automatic t_pwm();
      pa_pwm_route_type r [3] = '{PA_PWM_BIT3, PA_PWM_BIT4, PA_PWM_OFF};
      logic [7:0] e [3] = '{8'h08, 8'h10, 8'h00};
      for (int i = 0; i < 3; i++)
      begin
         @(posedge mclk);
         dir <= 8'h18;
         pwm <= 1'b1;
         route <= r[i];
         tick();
         chk(pad_out & 8'h18, e[i]);
      end
      @(posedge mclk);
      dir <= 8'h00;
   endtask
   // wake needs sleep and a live input; disabled input reads zero
   task t_wake();
      @(posedge mclk);
      sleep <= 1'b1;
      wake_en <= 8'h40;
      ext_val[6] <= 1'b1;
      watch(1, 1'b1);
      @(posedge mclk);
      din[6] <= 1'b0;
      watch(1, 1'b0);
      chk(port_read[6], 1'b0);
      @(posedge mclk);
      ext_val[6] <= 1'b0;
      watch(1, 1'b0);
      @(posedge mclk);
      sleep <= 1'b0;
      din <= 8'hff;
      ext_val[6] <= 1'b1;
      watch(1, 1'b0);
   endtask
   ////////////////////////////////////////
   // free-running clock
   initial
      forever #10 mclk = ~mclk;
   // main sequence
   initial
   begin
      repeat (16) @(posedge mclk);
      chk(pad_oe, 8'h00);
      chk(hrst_n, 1'b1);
      rst_n <= 1'b1;
      t_drive();
      t_irq();
      t_comp();
      t_pwm();
      t_wake();
      test_done();
   end
endmodule
`default_nettype wire
